// ---- rtl/fpsar_pkg.sv ----
/*
 * Constants for the fan pressure select and auto restart block:
 * register map, field positions, reset values and timing counts.
 * Assumes a 50 MHz system clock and a 1 ms time base.
 */
package fpsar_pkg;

	// ****************************************
	// Clock and time base
	// ****************************************
	localparam int unsigned CLK_NS = 20;
	localparam int unsigned TICK_NS = 1000000;
	localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;

	// ****************************************
	// Register map (byte offsets)
	// ****************************************
	localparam logic [7:0] OFF_PCODE = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_REMOTE = 8'h08;
	localparam logic [7:0] OFF_COND = 8'h0C;

	// ****************************************
	// Fields and reset values
	// ****************************************
	localparam logic [3:0] PCODE_RST = 4'h0;
	localparam logic [3:0] PCODE_MAX = 4'h4;
	localparam logic [15:0] COND_RST = 16'h0000;
	localparam logic AR_RST = 1'b0;
	localparam int ST_LEVEL_LSB = 0;
	localparam int ST_AR_BIT = 2;
	localparam int ST_RUN_BIT = 3;
	localparam int ST_LAMP_BIT = 4;
	localparam int ST_BEEP_BIT = 5;
	localparam int ST_WAIT_BIT = 6;
	localparam int REM_ON_BIT = 0;
	localparam int REM_OFF_BIT = 1;

	// ****************************************
	// Timing, set in seconds, minutes or counts and converted to milliseconds of the time base
	// ****************************************
	localparam int unsigned HOLD_MIN_S = 3;
	localparam int unsigned HOLD_MAX_S = 10;
	localparam int unsigned BLINK_S = 5;
	localparam int unsigned BLINK_RATE = 5;
	localparam int unsigned BEEP_MS = 100;
	localparam int unsigned BEEP_COUNT = 3;
	localparam int unsigned RESTART_MIN = 3;
	localparam logic [13:0] HOLD_MIN_MS = 14'(HOLD_MIN_S * 1000);
	localparam logic [13:0] HOLD_MAX_MS = 14'(HOLD_MAX_S * 1000);
	localparam logic [12:0] BLINK_MS = 13'(BLINK_S * 1000);
	localparam logic [6:0] BLINK_HALF_MS = 7'(1000 / (2 * BLINK_RATE));
	localparam logic [6:0] BEEP_PH_MS = 7'(BEEP_MS);
	localparam logic [2:0] BEEP_PHASES = 3'(2 * BEEP_COUNT);
	localparam int unsigned RESTART_MS = RESTART_MIN * 60 * 1000;

	typedef enum logic {FPSAR_BTN_IDLE, FPSAR_BTN_HELD} fpsar_btn_e;

endpackage : fpsar_pkg

// ---- rtl/fpsar_tick.sv ----
/*
 * Time base divider: one-cycle enable pulse every TICK_CYCLES clocks.
 * Assumes a single synchronous clock and an active-high synchronous reset.
 */
`timescale 1ns/1ns
`default_nettype none
module fpsar_tick
	import fpsar_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYC
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Enable pulse
	output logic tick_o
);

	logic [31:0] cnt_q;
	logic [31:0] cnt_d;
	logic tick_d;
	logic tick_q;

	always_comb
	begin
		tick_d = 1'b0;
		cnt_d = cnt_q + 32'h00000001;
		if (cnt_q >= 32'(TICK_CYCLES - 1))
		begin
			cnt_d = 32'h00000000;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt_q <= 32'h00000000;
			tick_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick_o = tick_q;

endmodule : fpsar_tick
`default_nettype wire

// ---- rtl/fpsar_top.sv ----
/*
 * Fan static pressure selection and auto restart control, with a
 * classic Wishbone register slave. power_good_i low models a supply
 * outage; retained state survives it and is cleared by rst_i, a bus write or, for the flag, a qualifying hold.
 * Button and switch inputs are synchronous and already debounced.
 */
// Chosen here: register access over Wishbone and the register offsets.
// Operation
// [R1] Code zero: switches pick 10/20/35/45 Pa
// [R2] Switches off select lowest level
// [R3] Codes one to four map to levels
// [R4] Nonzero code overrides the switches
// [R5] Code resets to zero
// [R6] Auto restart resumes three minutes after power
// [R7] Auto restart flag starts cleared
// [R8] Three second hold requests flag set
// [R9] Qualifying hold between three and ten seconds
// [R10] Setting beeps thrice, blinks lamp five seconds
// [R11] Press on standby starts unit at once
// [R12] Press while running stops unit at once
// [R13] Repeated hold clears flag with beeps
// [R14] Flag clear: stay off after power returns
// [R15] Clearing beeps but does not blink
// [R16] Flag, code, conditions survive power loss
// [R17] Timing counted from clock-derived time base
`timescale 1ns/1ns
`default_nettype none
module fpsar_top
	import fpsar_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYC,
	parameter int unsigned RESTART_TICKS = RESTART_MS
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Board inputs
	input wire logic power_good_i,
	input wire logic [1:0] pressure_select_switches_i,
	input wire logic manual_toggle_button_i,
	// Unit outputs
	output logic [1:0] pressure_level_o,
	output logic running_o,
	output logic green_lamp_o,
	output logic beep_o,
	output logic [15:0] op_cond_o
);

	// ****************************************
	// State
	// ****************************************
	logic tick;
	logic [3:0] pcode_q, pcode_d;
	logic [15:0] cond_q, cond_d;
	logic ar_q, ar_d;
	logic run_q, run_d;
	logic pg_q;
	fpsar_btn_e btn_q, btn_d;
	logic [13:0] hold_q, hold_d;
	logic wait_q, wait_d;
	logic [31:0] rcnt_q, rcnt_d;
	logic [12:0] blink_q, blink_d;
	logic [6:0] bph_q, bph_d;
	logic blvl_q, blvl_d;
	logic [2:0] beep_ph_q, beep_ph_d;
	logic [6:0] beep_ms_q, beep_ms_d;
	logic [1:0] level_q, level_d;
	logic run_out_q, run_out_d;
	logic lamp_q, lamp_d;
	logic beep_q, beep_d;
	logic ack_q, ack_d;
	logic [31:0] dat_q, dat_d;
	logic wr_en;
	logic hold_ok;

	fpsar_tick #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_o(tick)
	);

	assign wr_en = cyc_i & stb_i & we_i & ack_q & power_good_i;
	assign hold_ok = (hold_q > HOLD_MIN_MS) && (hold_q < HOLD_MAX_MS);

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		pcode_d = pcode_q;
		cond_d = cond_q;
		ar_d = ar_q;
		run_d = run_q;
		btn_d = btn_q;
		hold_d = hold_q;
		wait_d = wait_q;
		rcnt_d = rcnt_q;
		blink_d = blink_q;
		bph_d = bph_q;
		blvl_d = blvl_q;
		beep_ph_d = beep_ph_q;
		beep_ms_d = beep_ms_q;
		ack_d = cyc_i & stb_i & ~ack_q;
		dat_d = dat_q;
		// Register reads
		if (cyc_i & stb_i & ~ack_q)
		begin
			dat_d = 32'h00000000;
			case (adr_i)
				OFF_PCODE: dat_d[3:0] = pcode_q;
				OFF_STATUS:
				begin
					dat_d[ST_LEVEL_LSB +: 2] = level_q;
					dat_d[ST_AR_BIT] = ar_q;
					dat_d[ST_RUN_BIT] = run_out_q;
					dat_d[ST_LAMP_BIT] = lamp_q;
					dat_d[ST_BEEP_BIT] = beep_q;
					dat_d[ST_WAIT_BIT] = wait_q;
				end
				OFF_COND: dat_d[15:0] = cond_q;
				default: dat_d = 32'h00000000;
			endcase
		end
		// Register writes; out-of-range codes are ignored
		if (wr_en && sel_i[0] && adr_i == OFF_PCODE && dat_i[3:0] <= PCODE_MAX)
			pcode_d = dat_i[3:0]; // [R3]
		if (wr_en && adr_i == OFF_COND)
		begin
			if (sel_i[0])
				cond_d[7:0] = dat_i[7:0];
			if (sel_i[1])
				cond_d[15:8] = dat_i[15:8];
		end
		if (wr_en && sel_i[0] && adr_i == OFF_REMOTE)
		begin
			if (dat_i[REM_ON_BIT])
			begin
				run_d = 1'b1;
				wait_d = 1'b0;
			end
			else if (dat_i[REM_OFF_BIT])
			begin
				run_d = 1'b0;
				wait_d = 1'b0;
			end
		end
		// Restart delay after power return
		if (wait_q && tick)
		begin
			if (rcnt_q >= 32'(RESTART_TICKS - 1))
				wait_d = 1'b0; // [R6] [R17]
			else
				rcnt_d = rcnt_q + 32'h00000001;
		end
		// Beep and blink sequencers
		if (beep_ph_q != 3'h0 && tick)
		begin
			if (beep_ms_q == BEEP_PH_MS - 7'h01)
			begin
				beep_ms_d = 7'h00;
				beep_ph_d = beep_ph_q - 3'h1;
			end
			else
				beep_ms_d = beep_ms_q + 7'h01;
		end
		if (blink_q != 13'h0000 && tick)
		begin
			blink_d = blink_q - 13'h0001;
			if (bph_q == BLINK_HALF_MS - 7'h01)
			begin
				bph_d = 7'h00;
				blvl_d = ~blvl_q;
			end
			else
				bph_d = bph_q + 7'h01;
		end
		// Manual toggle button
		case (btn_q)
			FPSAR_BTN_IDLE:
			begin
				if (manual_toggle_button_i && power_good_i)
				begin
					btn_d = FPSAR_BTN_HELD;
					hold_d = 14'h0000;
					run_d = ~(run_q & ~wait_q); // [R11] [R12]
					wait_d = 1'b0;
				end
			end
			FPSAR_BTN_HELD:
			begin
				if (tick && hold_q < HOLD_MAX_MS)
					hold_d = hold_q + 14'h0001; // [R17]
				if (!manual_toggle_button_i)
				begin
					btn_d = FPSAR_BTN_IDLE;
					if (hold_ok && power_good_i) // [R8] [R9]
					begin
						ar_d = ~ar_q; // [R13]
						beep_ph_d = BEEP_PHASES; // [R10] [R13]
						beep_ms_d = 7'h00;
						blink_d = ar_q ? 13'h0000 : BLINK_MS; // [R10] [R15]
						bph_d = 7'h00;
						blvl_d = 1'b1;
					end
				end
			end
			default: btn_d = FPSAR_BTN_IDLE;
		endcase
		// Outage and power return; retained state is left alone
		if (!power_good_i)
		begin
			btn_d = FPSAR_BTN_IDLE;
			hold_d = 14'h0000;
			wait_d = 1'b0;
			beep_ph_d = 3'h0;
			blink_d = 13'h0000;
		end
		else if (!pg_q)
		begin
			if (ar_q && run_q)
			begin
				wait_d = 1'b1; // [R6]
				rcnt_d = 32'h00000000;
			end
			else
				run_d = 1'b0; // [R14]
		end
		level_d = (pcode_q == PCODE_RST) ? pressure_select_switches_i // [R1] [R2]
			: 2'(pcode_q - 4'h1); // [R3] [R4]
		run_out_d = run_d & power_good_i & ~wait_d;
		lamp_d = (blink_d != 13'h0000) ? blvl_d : run_out_d;
		beep_d = (beep_ph_d != 3'h0) && !beep_ph_d[0];
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pcode_q <= PCODE_RST; // [R5] [R16]
			cond_q <= COND_RST;
			ar_q <= AR_RST; // [R7] [R16]
			run_q <= 1'b0;
			pg_q <= 1'b0;
			btn_q <= FPSAR_BTN_IDLE;
			hold_q <= 14'h0000;
			wait_q <= 1'b0;
			rcnt_q <= 32'h00000000;
			blink_q <= 13'h0000;
			bph_q <= 7'h00;
			blvl_q <= 1'b0;
			beep_ph_q <= 3'h0;
			beep_ms_q <= 7'h00;
			level_q <= 2'h0;
			run_out_q <= 1'b0;
			lamp_q <= 1'b0;
			beep_q <= 1'b0;
			ack_q <= 1'b0;
			dat_q <= 32'h00000000;
		end
		else
		begin
			pcode_q <= pcode_d;
			cond_q <= cond_d;
			ar_q <= ar_d;
			run_q <= run_d;
			pg_q <= power_good_i;
			btn_q <= btn_d;
			hold_q <= hold_d;
			wait_q <= wait_d;
			rcnt_q <= rcnt_d;
			blink_q <= blink_d;
			bph_q <= bph_d;
			blvl_q <= blvl_d;
			beep_ph_q <= beep_ph_d;
			beep_ms_q <= beep_ms_d;
			level_q <= level_d;
			run_out_q <= run_out_d;
			lamp_q <= lamp_d;
			beep_q <= beep_d;
			ack_q <= ack_d;
			dat_q <= dat_d;
		end
	end

	assign dat_o = dat_q;
	assign ack_o = ack_q;
	assign pressure_level_o = level_q;
	assign running_o = run_out_q;
	assign green_lamp_o = lamp_q;
	assign beep_o = beep_q;
	assign op_cond_o = cond_q;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_release_ok;
		btn_q == FPSAR_BTN_HELD && !manual_toggle_button_i && hold_ok && power_good_i;
	endsequence

	sequence s_release_short;
		btn_q == FPSAR_BTN_HELD && !manual_toggle_button_i && !hold_ok && power_good_i;
	endsequence

	chk_switch_level: assert property (pcode_q == 4'h0 |=> // [R1]
		pressure_level_o == $past(pressure_select_switches_i))
		else $error("switch level not followed");
	chk_code_level: assert property (pcode_q != 4'h0 |=> // [R4]
		pressure_level_o == 2'($past(pcode_q) - 4'h1))
		else $error("code level wrong");
	chk_code_range: assert property (pcode_q <= 4'h4) // [R3]
		else $error("code out of range");
	chk_reset_defaults: assert property ($fell(rst_i) |-> // [R5]
		pcode_q == 4'h0 && !ar_q && !running_o)
		else $error("reset defaults wrong");
	chk_press_toggle: assert property (btn_q == FPSAR_BTN_IDLE && // [R11]
		manual_toggle_button_i && power_good_i |=> running_o != $past(running_o))
		else $error("press did not toggle unit");
	chk_hold_set: assert property (s_release_ok |=> ar_q != $past(ar_q) // [R8]
		##0 beep_o ##0 beep_ph_q == BEEP_PHASES ##1 beep_o[*7])
		else $error("qualifying hold mishandled");
	chk_short_hold: assert property (s_release_short |=> $stable(ar_q)) // [R9]
		else $error("short or long hold changed flag");
	chk_set_blink: assert property ($rose(ar_q) |-> blink_q == 13'(5000)) // [R10]
		else $error("no blink on set");
	chk_clear_quiet: assert property ($fell(ar_q) && power_good_i |-> // [R15]
		blink_q == 13'h0000 && beep_ph_q == 3'h6)
		else $error("clear blinked or no beep");
	chk_restart_wait: assert property ($rose(power_good_i) && ar_q && run_q |=> // [R6]
		wait_q && !running_o)
		else $error("restart delay not started");
	chk_no_restart: assert property ($rose(power_good_i) && !ar_q |=> // [R14]
		!run_q [*2])
		else $error("unit restarted without flag");
	chk_outage_keep: assert property (!power_good_i |=> // [R16]
		$stable(ar_q) && $stable(pcode_q) && $stable(cond_q))
		else $error("retained state lost");
	chk_hold_tick: assert property (btn_q == FPSAR_BTN_HELD && !tick && // [R17]
		manual_toggle_button_i && power_good_i |=> $stable(hold_q))
		else $error("hold counted without tick");

endmodule : fpsar_top
`default_nettype wire

// ---- verif/fpsar_btn_model.sv ----
/*
 * Push button model: presses the toggle button for a set count of clocks.
 * Assumes go_i pulses for one cycle while the model is idle.
 */
`timescale 1ns/1ns
`default_nettype none
module fpsar_btn_model
(
	// Clock
	input wire logic clk_i,
	// Request
	input wire logic go_i,
	input wire logic [15:0] hold_i,
	// Button
	output logic btn_o
);
	logic [15:0] cnt_q = 16'h0000;
	initial btn_o = 1'b0;
	always @(posedge clk_i)
	begin
		if (go_i)
		begin
			cnt_q <= hold_i;
			btn_o <= 1'b1;
		end
		else if (cnt_q != 16'h0000)
		begin
			cnt_q <= cnt_q - 16'h0001;
			btn_o <= (cnt_q != 16'h0001);
		end
	end
endmodule : fpsar_btn_model
`default_nettype wire

// ---- verif/fpsar_top_tb.sv ----
/*
 * Self-checking bench for fpsar_top: bus reads are queued and compared.
 * Assumes a 4-clock tick and a 20-tick restart delay.
 */
`timescale 1ns/1ns
`default_nettype none
module fpsar_top_tb
	import fpsar_pkg::*;
;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [31:0] dat_i = 32'h0, dat_o, rd;
	logic ack_o, running_o, green_lamp_o, beep_o, btn, go = 1'b0, pwr = 1'b1;
	logic [1:0] sw = 2'h0, pressure_level_o;
	logic [15:0] hold = 16'h0, op_cond_o;
	logic [31:0] exp_q[$];
	int bad_count = 0, total_checks = 0;
	initial forever #10 clk_i = ~clk_i;
	fpsar_top #(.TICK_CYCLES(4), .RESTART_TICKS(20)) dut (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .power_good_i(pwr),
		.pressure_select_switches_i(sw), .manual_toggle_button_i(btn),
		.pressure_level_o(pressure_level_o), .running_o(running_o),
		.green_lamp_o(green_lamp_o), .beep_o(beep_o), .op_cond_o(op_cond_o));
	fpsar_btn_model btn_m (.clk_i(clk_i), .go_i(go), .hold_i(hold), .btn_o(btn));
	// ****************************************
	// Checking and bus tasks
	// ****************************************
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
		total_checks++;
		if (seen !== ex)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, ex, seen);
		end
	endtask : chk
	task close_out;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	// Reads carry the expected word in d
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		if (!w)
			exp_q.push_back(d);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_o !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			bad_count++;
			close_out();
		end
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	always @(posedge clk_i)
		if (ack_o === 1'b1 && we_i === 1'b0)
		begin
			rd = exp_q.pop_front();
			chk("read data", dat_o, rd);
		end
	task press(input int c);
		go <= 1'b1;
		hold <= 16'(c);
		@(posedge clk_i);
		go <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask : press
	// Counts beeps and lamp changes over one second
	task obs(input int nb, input int lo, input int hi);
		int b, l;
		logic pb, pl;
		b = 0;
		l = 0;
		pb = beep_o;
		pl = green_lamp_o;
		repeat (4000)
		begin
			@(posedge clk_i);
			b += int'(beep_o & !pb);
			l += int'(green_lamp_o != pl);
			pb = beep_o;
			pl = green_lamp_o;
		end
		chk("beeps", b, nb);
		chk("lamp changes", (l >= lo && l <= hi), 1);
	endtask : obs
	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		int v, n;
		void'($urandom(32'hE6AA330B));
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk("level", pressure_level_o, 0);
		for (int i = 0; i < 4; i++)
		begin
			sw <= 2'(i);
			repeat (3) @(posedge clk_i);
			chk("level", pressure_level_o, i);
		end
		wb(0, OFF_PCODE, 0);
		for (int c = 1; c < 6; c++)
		begin
			wb(1, OFF_PCODE, c);
			sw <= 2'($urandom);
			repeat (3) @(posedge clk_i);
			chk("level", pressure_level_o, (c > 4) ? 3 : c - 1);
		end
		wb(0, OFF_PCODE, 4);
		v = $urandom & 32'h0000FFFF;
		wb(1, OFF_COND, v);
		chk("cond", op_cond_o, v);
		wb(0, OFF_COND, v);
		press(400);
		chk("running", running_o, 1);
		repeat (1000) @(posedge clk_i);
		wb(0, OFF_STATUS, 32'h1B);
		press(14000);
		chk("running", running_o, 0);
		repeat (13990) @(posedge clk_i);
		obs(3, 9, 11);
		repeat (17000) @(posedge clk_i);
		wb(0, OFF_STATUS, 32'h07);
		press(400);
		repeat (1000) @(posedge clk_i);
		wb(0, OFF_STATUS, 32'h1F);
		pwr <= 1'b0;
		repeat (20) @(posedge clk_i);
		pwr <= 1'b1;
		@(posedge clk_i);
		n = 0;
		while (running_o !== 1'b1 && n < 400)
		begin
			@(posedge clk_i);
			n++;
		end
		chk("restart delay", (n >= 76 && n <= 100), 1);
		if (n >= 400)
			close_out();
		wb(0, OFF_COND, v);
		chk("cond", op_cond_o, v);
		press(14000);
		chk("running", running_o, 0);
		repeat (13990) @(posedge clk_i);
		obs(3, 0, 0);
		wb(0, OFF_STATUS, 32'h03);
		wb(1, OFF_REMOTE, 1);
		pwr <= 1'b0;
		wb(1, OFF_PCODE, 1);
		repeat (20) @(posedge clk_i);
		pwr <= 1'b1;
		repeat (400) @(posedge clk_i);
		chk("running", running_o, 0);
		wb(0, OFF_PCODE, 4);
		wb(1, OFF_REMOTE, 1);
		repeat (3) @(posedge clk_i);
		chk("running", running_o, 1);
		wb(1, OFF_REMOTE, 2);
		repeat (3) @(posedge clk_i);
		chk("running", running_o, 0);
		close_out();
	end
endmodule : fpsar_top_tb
`default_nettype wire
